// *** aps_sequencer.sv ***
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "aps_consts.svh"
module aps_sequencer #(
	parameter int STAGES = 16,
	parameter int TENTH_CYCLES = `APS_TENTH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire aps_pkg::aps_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Run command and other drive functions
	input wire logic run_cmd,
	input wire logic wobble_active,
	input wire logic pid_active,
	input wire logic [15:0] speed0_freq,
	input wire logic [3:0] ext_step_sel,
	// Reference to ramp and modulation stages
	output aps_pkg::aps_ref_t ref_out,
	output logic use_general_ramp,
	output logic [3:0] ramp_time_sel
);
	import aps_pkg::*;

	// Sequencer states; status reads them back as a 2-bit code
	typedef enum logic [1:0] {
		S_IDLE, // Waiting for a run edge
		S_RUN, // Stepping through stages
		S_HOLD, // Parked on the last stage
		S_DONE // Cycle done, output stopped
	} aps_state_t;

	// Stage tables, written by software
	// Entry 0 of the frequency table stays unused, stage 0 reads the pin
	logic [15:0] freq_tab [STAGES]; // Hundredths of a hertz
	logic [15:0] time_tab [STAGES]; // Tenths of a second
	logic [1:0] dir_tab [STAGES]; // Stop, forward or reverse
	logic [2:0] mode; // Program mode code
	logic [1:0] ctrl; // Spare control bits
	// Sequencer state
	aps_state_t state; // Current state
	logic [3:0] stage; // Stage being run
	logic [15:0] tenths; // Tenths elapsed in this stage
	logic [31:0] tick_cnt; // Cycles within one tenth
	logic tick; // One-cycle tenth pulse
	logic run_d; // Run command one cycle late
	logic ack; // Bus answer cycle

	// Offset decode helpers
	// A bank is sixteen aligned words picked by the top two offset bits
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		in_bank = (a[7:6] == base[7:6]) && (a[1:0] == 2'h0);
	endfunction
	// Clamp a written word to the setting's top value
	// Upper bits set count as over range, so a wild write never wraps
	function automatic logic [15:0] clip(input logic [31:0] v, input logic [15:0] lim);
		clip = (v[15:0] > lim || v[31:16] != 16'h0) ? lim : v[15:0];
	endfunction

	// Bus decode
	wire logic [3:0] idx = avs_req.address[5:2];
	wire logic hit_freq = in_bank(avs_req.address, `APS_REG_FREQ_BASE);
	wire logic hit_time = in_bank(avs_req.address, `APS_REG_TIME_BASE);
	wire logic hit_dir = in_bank(avs_req.address, `APS_REG_DIR_BASE);
	wire logic hit_mode = avs_req.address == `APS_REG_MODE;
	wire logic hit_stat = avs_req.address == `APS_REG_STATUS;
	wire logic hit_ctrl = avs_req.address == `APS_REG_CTRL;
	// A request counts only outside the answer cycle
	wire logic req = (avs_req.read | avs_req.write) & ~ack;
	// Writes land in the answer cycle, where the master sees waitrequest low
	wire logic wr = avs_req.write & ack;

	// zero durations
	// Any zero duration among the stages blocks the program
	// A plain OR over the table, cheap and settled every cycle
	logic any_zero;
	always_comb begin
		any_zero = 1'b0;
		for (int i = 0; i < STAGES; i++) begin
			if (time_tab[i] == 16'h0) begin
				any_zero = 1'b1;
			end
		end
	end

	// Program needs a legal mode, full durations, no wobble and no PID
	// inhibit check
	wire logic enabled = (mode != 3'h0) && (mode <= 3'h6) && !any_zero
		&& !wobble_active && !pid_active;
	// Live request from the run command
	wire logic active = enabled && run_cmd;
	// A start needs a fresh run edge, so a held run never restarts alone
	wire logic run_rise = run_cmd & ~run_d;
	// Mode groups by end-of-cycle behaviour
	wire logic once_stop = (mode == 3'h1) || (mode == 3'h4);
	wire logic repeat_mode = (mode == 3'h2) || (mode == 3'h5);
	// Upper group restarts from stage zero
	wire logic restart_zero = mode >= 3'h4;
	// Stage end falls on the tick that completes its last tenth
	wire logic last_stage = stage == 4'(STAGES - 1);
	wire logic stage_end = tick && (tenths + 16'h1 >= time_tab[stage]);

	// Read mux
	// Unmapped offsets read as zero; status packs state, enable and stage
	logic [31:0] rdata;
	always_comb begin
		rdata = `APS_READ_NONE;
		if (hit_freq) begin
			rdata = {16'h0, freq_tab[idx]};
		end else if (hit_time) begin
			rdata = {16'h0, time_tab[idx]};
		end else if (hit_dir) begin
			rdata = {30'h0, dir_tab[idx]};
		end else if (hit_mode) begin
			rdata = {29'h0, mode};
		end else if (hit_ctrl) begin
			rdata = {30'h0, ctrl};
		end else if (hit_stat) begin
			rdata = {24'h0, 2'(state), 1'b0, enabled, stage};
		end
	end

	// One wait cycle then answer; ack clears next cycle
	// Waitrequest has its own flop so the port comes straight from a register
	always_ff @(posedge clk) begin
		if (reset) begin
			ack <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			ack <= req;
			// Low only in the answer cycle
			avs_waitrequest <= ~req;
			// Captured at acceptance, stands until the next access
			if (req) begin
				avs_readdata <= rdata;
			end
		end
	end

	// Register writes in the answer cycle of the request
	always_ff @(posedge clk) begin
		if (reset) begin
			mode <= `APS_MODE_RESET;
			ctrl <= `APS_CTRL_RESET;
			for (int i = 0; i < STAGES; i++) begin
				freq_tab[i] <= 16'h0;
				time_tab[i] <= 16'h0;
				dir_tab[i] <= 2'h0;
			end
		end else if (wr) begin
			// Mode and spare control words keep only their low bits
			if (hit_mode) begin
				mode <= avs_req.writedata[2:0];
			end
			if (hit_ctrl) begin
				ctrl <= avs_req.writedata[1:0];
			end
			// Stage 0 takes its frequency from the pin, not this table
			// frequency table
			if (hit_freq && idx != 4'h0) begin
				freq_tab[idx] <= clip(avs_req.writedata, `APS_FREQ_MAX);
			end
			if (hit_time) begin
				time_tab[idx] <= clip(avs_req.writedata, `APS_TIME_MAX);
			end
			// Code 3 has no meaning, the entry keeps its old value
			// direction table
			if (hit_dir && avs_req.writedata[1:0] != 2'h3) begin
				dir_tab[idx] <= avs_req.writedata[1:0];
			end
		end
	end

	// Tenth of a second enable, runs only while stepping
	// Clears outside the run state, so a resumed stage starts a fresh tenth
	// Limitation: the part of a tenth run before a stop is lost
	always_ff @(posedge clk) begin
		if (reset || state != S_RUN || !active) begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == 32'(TENTH_CYCLES - 1);
			tick_cnt <= (tick_cnt == 32'(TENTH_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
		end
	end

	// Stage sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= S_IDLE;
			stage <= 4'h0;
			tenths <= 16'h0;
			run_d <= 1'b0;
		end else begin
			run_d <= run_cmd;
			case (state)
				S_IDLE: begin
					// Lower group keeps stage and elapsed tenths here
					if (active && run_rise) begin
						state <= S_RUN;
						if (restart_zero) begin
							stage <= 4'h0;
							tenths <= 16'h0;
						end
					end
				end
				S_RUN: begin
					if (!active) begin
						// Stage and tenths stay as they were
						// keep unfinished stage
						state <= S_IDLE;
					end else if (stage_end) begin
						tenths <= 16'h0;
						if (!last_stage) begin
							stage <= stage + 4'h1;
						end else if (repeat_mode) begin
							stage <= 4'h0;
						end else if (once_stop) begin
							state <= S_DONE;
							stage <= 4'h0;
						end else begin
							state <= S_HOLD;
						end
					end else if (tick) begin
						tenths <= tenths + 16'h1;
					end
				end
				S_HOLD: begin
					// Run drop ends the hold; the next start is from stage zero
					if (!active) begin
						state <= S_IDLE;
						stage <= 4'h0;
					end
				end
				S_DONE: begin
					// Stay stopped until run is released or the program is disabled
					if (!run_cmd || !enabled) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Drive reference out
	// Outputs are registered, so they trail the state by one cycle
	// Live while the program owns the reference
	logic live;
	assign live = active && (state == S_RUN || state == S_HOLD);
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_out <= '0;
			use_general_ramp <= 1'b0;
			ramp_time_sel <= 4'h0;
		end else begin
			ref_out.active <= live;
			ref_out.stage <= stage;
			use_general_ramp <= live;
			// Step inputs pass through only while the program is idle
			// ignore step inputs
			ramp_time_sel <= live ? 4'h0 : ext_step_sel;
			if (!live || dir_tab[stage] == APS_DIR_STOP) begin
				ref_out.freq <= 16'h0;
				ref_out.dir <= APS_DIR_STOP;
			end else begin
				ref_out.freq <= (stage == 4'h0) ? speed0_freq : freq_tab[stage];
				ref_out.dir <= dir_tab[stage];
			end
		end
	end
endmodule // aps_sequencer

// *** aps_consts.svh ***
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH
// Clock rate and time base
`define APS_CLK_HZ 25000000
`define APS_TENTH_SEC_NS 100000000
// Cycles per tenth of a second at the clock rate
`define APS_TENTH_CYCLES ((`APS_TENTH_SEC_NS / 1000) * (`APS_CLK_HZ / 1000000))
// Stage setting limits
`define APS_FREQ_MAX 16'hE9FC
`define APS_TIME_MAX 16'hEA60
// Register map
`define APS_REG_MODE 8'h00
`define APS_REG_STATUS 8'h04
`define APS_REG_CTRL 8'h08
`define APS_REG_FREQ_BASE 8'h40
`define APS_REG_TIME_BASE 8'h80
`define APS_REG_DIR_BASE 8'hC0
// Reset values
`define APS_MODE_RESET 3'h0
`define APS_CTRL_RESET 2'h0
// Unmapped read answer
`define APS_READ_NONE 32'h0000_0000
`endif

// *** aps_pkg.sv ***
package aps_pkg;
	// Direction selector per stage
	typedef enum logic [1:0] {
		APS_DIR_STOP = 2'h0,
		APS_DIR_FWD = 2'h1,
		APS_DIR_REV = 2'h2
	} aps_dir_t;
	// Avalon request bundle
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} aps_req_t;
	// Reference to the ramp stage
	typedef struct packed {
		logic active;
		logic [1:0] dir;
		logic [15:0] freq;
		logic [3:0] stage;
	} aps_ref_t;
endpackage

// *** aps_sequencer_chk.sv ***
`timescale 1ns/1ps
module aps_chk (
	// Clock, reset, bus
	input wire logic clk,
	input wire logic reset,
	input wire aps_pkg::aps_req_t avs_req,
	input wire logic avs_waitrequest,
	// Drive inputs and reference
	input wire logic wobble_active,
	input wire logic pid_active,
	input wire logic [15:0] speed0_freq,
	input wire aps_pkg::aps_ref_t ref_out,
	input wire logic use_general_ramp,
	input wire logic [3:0] ramp_time_sel
);
	import aps_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_ack_next: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("ack late");
	chk_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack long");
	chk_inhibit_hold: assert property ((wobble_active || pid_active) && !ref_out.active
		|=> !ref_out.active) else $error("ran while inhibited");
	chk_general_ramp: assert property (ref_out.active && $past(ref_out.active)
		|-> use_general_ramp) else $error("ramp select");
	chk_steps_ignored: assert property (use_general_ramp
		|-> ramp_time_sel == 4'h0) else $error("step select");
	chk_stop_zero: assert property (ref_out.active && ref_out.dir == 2'h0
		|-> ref_out.freq == 16'h0) else $error("stop freq");
	chk_dir_legal: assert property (ref_out.active |-> ref_out.dir != 2'h3)
		else $error("bad dir");
	chk_stage_step: assert property (ref_out.active && $past(ref_out.active)
		&& ref_out.stage != $past(ref_out.stage)
		|-> ref_out.stage == $past(ref_out.stage) + 4'h1) else $error("stage skip");
	chk_stage0_freq: assert property (ref_out.active && ref_out.stage == 4'h0
		&& ref_out.dir != 2'h0 |-> ref_out.freq == speed0_freq) else $error("stage 0 freq");
endmodule // aps_chk
bind aps_sequencer aps_chk chk_u (.clk, .reset, .avs_req, .avs_waitrequest, .wobble_active,
	.pid_active, .speed0_freq, .ref_out, .use_general_ramp, .ramp_time_sel);

// *** aps_ramp_model.sv ***
`timescale 1ns/1ps
module aps_ramp_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Reference in, ramped output
	input wire aps_pkg::aps_ref_t ref_in,
	output logic [15:0] ramp_freq
);
	import aps_pkg::*;
	// One count a cycle, so step changes show as slopes
	always_ff @(posedge clk) begin
		if (reset) ramp_freq <= 16'h0;
		else if (ramp_freq < ref_in.freq) ramp_freq <= ramp_freq + 16'h1;
		else if (ramp_freq > ref_in.freq) ramp_freq <= ramp_freq - 16'h1;
	end
endmodule // aps_ramp_model

// *** auto_program_speed_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module auto_program_speed_sequencer_tb_top;
	import aps_pkg::*;
	logic clk, reset, run_cmd, wobble_active, pid_active, avs_waitrequest, use_general_ramp;
	logic [15:0] speed0_freq;
	logic [3:0] ext_step_sel, ramp_time_sel;
	logic [31:0] avs_readdata, q;
	aps_req_t avs_req;
	aps_ref_t ref_out;
	int n_errors = 0, check_count = 0, m, n;
	// Short tenth so a stage lasts about ten cycles
	aps_sequencer #(.TENTH_CYCLES(10)) dut_u (.clk, .reset, .avs_req, .avs_readdata,
		.avs_waitrequest, .run_cmd, .wobble_active, .pid_active, .speed0_freq, .ext_step_sel,
		.ref_out, .use_general_ramp, .ramp_time_sel);
	aps_ramp_model ramp_u (.clk, .reset, .ref_in(ref_out), .ramp_freq());
	always #20 clk = ~clk;
	task chk(string s, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	// Request held until waitrequest is seen low
	task bus(logic w, logic [7:0] a, logic [31:0] d);
		int i;
		i = 0;
		avs_req <= {~w, w, a, d};
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'b0);
		// Answer comes one cycle after the request is taken
		chk("ack wait", 32'h2, 32'(i));
		q = avs_readdata;
		avs_req <= '0;
		@(posedge clk);
	endtask
	// Bounded wait for a live stage
	task wt(logic [3:0] s);
		int i;
		for (i = 0; i < 400 && !(ref_out.active && ref_out.stage == s); i++) @(posedge clk);
		chk("stage", 32'(s), 32'(ref_out.stage));
	endtask
	task test_done;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		test_done();
	end
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		avs_req = '0;
		run_cmd = 1'b0;
		wobble_active = 1'b0;
		pid_active = 1'b0;
		speed0_freq = 16'h05DC;
		ext_step_sel = 4'hA;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Stage n: freq 100n, one tenth, dir cycles fwd/rev/stop
		for (n = 0; n < 16; n++) begin
			bus(1'b1, 8'h40 + 8'(4 * n), 32'(100 * n));
			bus(1'b1, 8'h80 + 8'(4 * n), 32'h1);
			bus(1'b1, 8'hC0 + 8'(4 * n), 32'((n + 1) % 3));
		end
		bus(1'b1, 8'h7C, 32'hFFFF);
		bus(1'b1, 8'hD0, 32'h3);
		bus(1'b1, 8'h40, 32'h123);
		bus(1'b0, 8'h40, 32'h0);
		chk("freq 0", 32'h0, q);
		bus(1'b0, 8'h54, 32'h0);
		chk("freq", 32'h1F4, q);
		bus(1'b0, 8'h7C, 32'h0);
		chk("freq clip", 32'hE9FC, q);
		bus(1'b0, 8'h94, 32'h0);
		chk("time", 32'h1, q);
		bus(1'b0, 8'hD0, 32'h0);
		chk("dir", 32'h2, q);
		bus(1'b0, 8'h0C, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test registers done");
		bus(1'b1, 8'h00, 32'h1);
		// Zero duration, wobble, then PID each block a start
		for (n = 0; n < 3; n++) begin
			bus(1'b1, 8'h9C, 32'(n > 0));
			wobble_active <= n == 1;
			pid_active <= n == 2;
			run_cmd <= 1'b1;
			repeat (20) @(posedge clk);
			chk("inhibit", 32'h0, 32'(ref_out.active));
			chk("steps", 32'hA, 32'(ramp_time_sel));
			run_cmd <= 1'b0;
			@(posedge clk);
		end
		pid_active <= 1'b0;
		$display("test inhibit done");
		// Each mode: break at stage 5, rerun, then watch the end
		for (m = 1; m < 7; m++) begin
			bus(1'b1, 8'h00, 32'(m));
			run_cmd <= 1'b1;
			wt(4'h5);
			run_cmd <= 1'b0;
			repeat (5) @(posedge clk);
			run_cmd <= 1'b1;
			repeat (4) @(posedge clk);
			chk("resume", m < 4 ? 5 : 0, 32'(ref_out.stage));
			wt(4'hF);
			repeat (30) @(posedge clk);
			chk("end", m % 3 == 1 ? 0 : m % 3 == 2 ? 1 : 15, m % 3 == 1 ? 32'(ref_out.freq) :
				m % 3 == 2 ? 32'(ref_out.active && ref_out.stage < 4'h4) : 32'(ref_out.stage));
			run_cmd <= 1'b0;
			repeat (5) @(posedge clk);
			$display("test mode %0d done", m);
		end
		test_done();
	end
endmodule // auto_program_speed_sequencer_tb_top
